// ---- hw/flash_poll_ctrl.sv ----
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "flash_poll_defines.svh"
module flash_poll_ctrl
    import flash_poll_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16,
    parameter int RD_CYC = `READ_CYC,
    parameter int WP_CYC = `WPULSE_CYC
) (
    input wire logic hclk, // system clock, 100 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word transfers only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    output logic flash_ce_n, // chip enable, active low
    output logic flash_oe_n, // output enable, active low
    output logic flash_we_n, // write strobe, active low
    output logic [ADDR_W-1:0] flash_addr, // word address
    output logic [DATA_W-1:0] flash_dq_out, // data driven to flash
    output logic flash_dq_oe_n, // low while we drive data
    input wire logic [DATA_W-1:0] flash_dq_in, // data from flash
    input wire logic busy_output_n // device busy, active low
);
    flash_cycle_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

    flash_cycle_engine #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .RD_CYC(RD_CYC), .WP_CYC(WP_CYC)) u_eng (
        .hclk(hclk),
        .hresetn(hresetn),
        .cyc(cyc),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe_n(flash_dq_oe_n),
        .flash_dq_in(flash_dq_in)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register bus

    logic wr_pend_reg;
    logic [7:0] wr_off_reg;
    logic skip_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] result_reg;
    logic start_reg;
    logic abort_reg;
    logic [2:0] op_reg;
    logic done_reg;
    logic ok_reg;
    logic fail_reg;
    logic sector_reg;
    logic susp_reg;
    logic rej_reg;
    logic winpre_reg;
    ctrl_state_t state_reg;
    logic [8:0] status_word;
    logic addr_phase;

    assign addr_phase = hsel && hready && htrans[1];
    assign status_word = {!busy_output_n, winpre_reg, rej_reg, susp_reg, sector_reg,
                          fail_reg, ok_reg, done_reg, state_reg != S_IDLE};

    function automatic logic [31:0] read_mux(input logic [7:0] off);
        case (off)
            `REG_CTRL: read_mux = {27'h0000000, skip_reg, 1'b0, op_reg};
            `REG_ADDR: read_mux = {{(32-ADDR_W){1'b0}}, addr_reg};
            `REG_WDATA: read_mux = {{(32-DATA_W){1'b0}}, wdata_reg};
            `REG_STATUS: read_mux = {23'h000000, status_word};
            `REG_RDATA: read_mux = {{(32-DATA_W){1'b0}}, result_reg};
            default: read_mux = 32'h00000000;
        endcase
    endfunction

    // zero wait states: read data is latched at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_off_reg <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_off_reg <= haddr[7:0];
                if (!hwrite) begin
                    hrdata <= read_mux(haddr[7:0]);
                end
            end
        end
    end

    // a start while busy is dropped; software polls the busy bit first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skip_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= '0;
            op_reg <= 3'h0;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            if (wr_pend_reg) begin
                case (wr_off_reg)
                    `REG_CTRL: begin
                        skip_reg <= hwdata[`CTRL_SKIP_WIN];
                        abort_reg <= hwdata[`CTRL_ABORT];
                        if (!hwdata[`CTRL_ABORT] && state_reg == S_IDLE) begin
                            op_reg <= hwdata[`CTRL_OP_LSB +: 3];
                            start_reg <= 1'b1;
                        end
                    end
                    `REG_ADDR: addr_reg <= hwdata[ADDR_W-1:0];
                    `REG_WDATA: wdata_reg <= hwdata[DATA_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status polling sequencer

    logic issued_reg;
    logic [DATA_W-1:0] rd1_reg;
    logic [DATA_W-1:0] rd2_reg;
    logic [3:0] poll_reads_reg;
    logic cyc_state;
    logic cyc_wr_sel;
    logic [DATA_W-1:0] cyc_wdata_sel;
    logic tog6;
    logic tog2;
    logic [DATA_W-1:0] rdata;

    assign rdata = cyc.rdata;
    assign tog6 = rd1_reg[`BIT_OP_TOGGLE] ^ rd2_reg[`BIT_OP_TOGGLE];
    assign tog2 = rd1_reg[`BIT_SECTOR_TOGGLE] ^ rd2_reg[`BIT_SECTOR_TOGGLE];

    always_comb begin
        cyc_state = !(state_reg == S_IDLE || state_reg == S_EVAL);
        cyc_wr_sel = (state_reg == S_RESET_CMD) || (state_reg == S_ERASE_WR) ||
                     (state_reg == S_SINGLE && op_reg == `OP_WRITE);
        cyc_wdata_sel = wdata_reg;
        if (state_reg == S_RESET_CMD) begin
            cyc_wdata_sel = `FLASH_RESET_DATA;
        end else if (state_reg == S_ERASE_WR) begin
            cyc_wdata_sel = `ERASE_CONFIRM_DATA;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
            issued_reg <= 1'b0;
            rd1_reg <= '0;
            rd2_reg <= '0;
            poll_reads_reg <= 4'h0;
            result_reg <= '0;
            done_reg <= 1'b0;
            ok_reg <= 1'b0;
            fail_reg <= 1'b0;
            sector_reg <= 1'b0;
            susp_reg <= 1'b0;
            rej_reg <= 1'b0;
            winpre_reg <= 1'b0;
            cyc.req <= 1'b0;
            cyc.wr <= 1'b0;
            cyc.addr <= '0;
            cyc.wdata <= '0;
        end else begin
            cyc.req <= 1'b0;
            if (abort_reg) begin
                state_reg <= S_IDLE;
                issued_reg <= 1'b0;
                poll_reads_reg <= 4'h0;
            end else if (start_reg) begin
                {done_reg, ok_reg, fail_reg, sector_reg, susp_reg, rej_reg, winpre_reg} <= 7'h00;
                poll_reads_reg <= 4'h0;
                case (op_reg)
                    `OP_READ, `OP_WRITE: state_reg <= S_SINGLE;
                    `OP_POLL: state_reg <= S_RD1;
                    `OP_ERASE_ADD: state_reg <= skip_reg ? S_ERASE_WR : S_WIN_PRE;
                    default: state_reg <= S_IDLE;
                endcase
            end else if (state_reg == S_EVAL) begin
                if (!tog6) begin
                    sector_reg <= tog2;
                    if (tog2) begin
                        susp_reg <= 1'b1;
                        done_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        state_reg <= S_FINAL;
                    end
                end else if (rd2_reg[`BIT_FAILURE]) begin
                    state_reg <= S_RECHK1;
                end else begin
                    rd1_reg <= rd2_reg;
                    state_reg <= S_RD2;
                end
            end else if (cyc_state && !issued_reg && cyc.idle) begin
                cyc.req <= 1'b1;
                cyc.wr <= cyc_wr_sel;
                cyc.addr <= addr_reg;
                cyc.wdata <= cyc_wdata_sel;
                issued_reg <= 1'b1;
            end else if (issued_reg && cyc.done) begin
                issued_reg <= 1'b0;
                case (state_reg)
                    S_SINGLE: begin
                        result_reg <= rdata;
                        {done_reg, ok_reg} <= 2'h3;
                        state_reg <= S_IDLE;
                    end
                    S_RD1, S_RD2: begin
                        if (state_reg == S_RD1) begin
                            rd1_reg <= rdata;
                        end else begin
                            rd2_reg <= rdata;
                        end
                        if (poll_reads_reg != 4'hF) begin
                            poll_reads_reg <= poll_reads_reg + 4'h1;
                        end
                        state_reg <= (state_reg == S_RD1) ? S_RD2 : S_EVAL;
                    end
                    S_RECHK1: begin
                        rd1_reg <= rdata;
                        state_reg <= S_RECHK2;
                    end
                    S_RECHK2: begin
                        rd2_reg <= rdata;
                        if ((rd1_reg[`BIT_OP_TOGGLE] ^ rdata[`BIT_OP_TOGGLE]) == 1'b1) begin
                            state_reg <= S_RESET_CMD;
                        end else begin
                            state_reg <= S_FINAL;
                        end
                    end
                    S_FINAL: begin
                        result_reg <= rdata;
                        {done_reg, ok_reg} <= 2'h3;
                        state_reg <= S_IDLE;
                    end
                    S_RESET_CMD: begin
                        {done_reg, fail_reg} <= 2'h3;
                        state_reg <= S_IDLE;
                    end
                    S_WIN_PRE: begin
                        winpre_reg <= rdata[`BIT_WINDOW];
                        state_reg <= S_ERASE_WR;
                    end
                    S_ERASE_WR: state_reg <= S_ACK1;
                    S_ACK1: begin
                        rd1_reg <= rdata;
                        state_reg <= S_ACK2;
                    end
                    S_ACK2: begin
                        rd2_reg <= rdata;
                        // accepted when the operation toggle moves or data poll reads zero
                        if (!((rd1_reg[`BIT_OP_TOGGLE] ^ rdata[`BIT_OP_TOGGLE]) ||
                              !rdata[`BIT_DATA_POLL])) begin
                            rej_reg <= 1'b1;
                        end
                        if (skip_reg) begin
                            {done_reg, ok_reg} <= 2'h3;
                            state_reg <= S_IDLE;
                        end else begin
                            state_reg <= S_WIN_POST;
                        end
                    end
                    S_WIN_POST: begin
                        // window closed after our command: it may have been dropped
                        if (rdata[`BIT_WINDOW]) begin
                            rej_reg <= 1'b1;
                        end
                        {done_reg, ok_reg} <= 2'h3;
                        state_reg <= S_IDLE;
                    end
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence recheck_still_toggling;
        state_reg == S_RECHK2 && issued_reg && cyc.done &&
        (rd1_reg[`BIT_OP_TOGGLE] != rdata[`BIT_OP_TOGGLE]);
    endsequence

    sequence reset_then_fail;
        state_reg == S_RESET_CMD ##[1:60] fail_reg;
    endsequence

    a_pair_before_eval: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == S_EVAL |-> poll_reads_reg >= 4'h2)
        else $error("status evaluated before two reads");

    a_steady_array_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == S_EVAL && !tog6 && !tog2) |=> state_reg == S_FINAL)
        else $error("steady toggle did not lead to array read");

    a_fail_recheck: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == S_EVAL && tog6 && rd2_reg[`BIT_FAILURE]) |=> state_reg == S_RECHK1)
        else $error("failure bit seen without recheck");

    a_fail_resets: assert property (@(posedge hclk) disable iff (!hresetn)
        recheck_still_toggling |=> reset_then_fail)
        else $error("failed operation not followed by reset and fail flag");

    a_reset_data: assert property (@(posedge hclk) disable iff (!hresetn)
        (cyc.req && state_reg == S_RESET_CMD) |-> (cyc.wr && cyc.wdata == `FLASH_RESET_DATA))
        else $error("reset command cycle carries wrong data");

    a_abort_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        abort_reg |=> (state_reg == S_IDLE && poll_reads_reg == 4'h0))
        else $error("abort did not restart polling");

    a_skip_window: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == S_WIN_PRE || state_reg == S_WIN_POST) |-> !skip_reg)
        else $error("window bit checked while skipping");

    a_window_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == S_WIN_POST && issued_reg && cyc.done && rdata[`BIT_WINDOW])
        |=> (rej_reg && done_reg))
        else $error("closed window after command not flagged");

    a_status_addr: assert property (@(posedge hclk) disable iff (!hresetn)
        cyc.req |-> cyc.addr == addr_reg)
        else $error("status read left the target sector");

    a_suspend_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == S_EVAL && !tog6 && tog2) |=> (susp_reg && sector_reg && !ok_reg))
        else $error("suspended sector not reported");
endmodule

// ---- hw/flash_poll_defines.svh ----
`ifndef FLASH_POLL_DEFINES_SVH
`define FLASH_POLL_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define T_READ_NS 70
`define T_WPULSE_NS 35
`define READ_CYC ((`T_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WPULSE_CYC ((`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_GAP_US 50

`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10

`define CTRL_OP_LSB 0
`define CTRL_SKIP_WIN 4
`define CTRL_ABORT 7

`define OP_READ 3'h1
`define OP_WRITE 3'h2
`define OP_POLL 3'h3
`define OP_ERASE_ADD 3'h4

`define ST_BUSY 0
`define ST_DONE 1
`define ST_OK 2
`define ST_FAIL 3
`define ST_ERASE_SECTOR 4
`define ST_SUSPENDED 5
`define ST_MAYBE_REJECTED 6
`define ST_WINDOW_PRE 7
`define ST_DEVICE_BUSY 8

`define BIT_DATA_POLL 7
`define BIT_OP_TOGGLE 6
`define BIT_FAILURE 5
`define BIT_WINDOW 3
`define BIT_SECTOR_TOGGLE 2

`define FLASH_RESET_DATA 16'h00F0
`define ERASE_CONFIRM_DATA 16'h0030

`endif

// ---- hw/flash_poll_pkg.sv ----
package flash_poll_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_SINGLE = 4'h1,
        S_RD1 = 4'h2,
        S_RD2 = 4'h3,
        S_EVAL = 4'h4,
        S_RECHK1 = 4'h5,
        S_RECHK2 = 4'h6,
        S_FINAL = 4'h7,
        S_RESET_CMD = 4'h8,
        S_WIN_PRE = 4'h9,
        S_ERASE_WR = 4'hA,
        S_ACK1 = 4'hB,
        S_ACK2 = 4'hC,
        S_WIN_POST = 4'hD
    } ctrl_state_t;

    typedef enum logic [1:0] {
        CYC_IDLE = 2'h0,
        CYC_STROBE = 2'h1,
        CYC_HOLD = 2'h2
    } cyc_state_t;
endpackage

// ---- hw/flash_cycle_if.sv ----
`timescale 1ns/1ps
interface flash_cycle_if #(parameter int ADDR_W = 22, parameter int DATA_W = 16) ();
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic idle;
    modport master (output req, output wr, output addr, output wdata,
                    input rdata, input done, input idle);
    modport engine (input req, input wr, input addr, input wdata,
                    output rdata, output done, output idle);
endinterface

// ---- hw/flash_cycle_engine.sv ----
`timescale 1ns/1ps
`include "flash_poll_defines.svh"
module flash_cycle_engine
    import flash_poll_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16,
    parameter int RD_CYC = `READ_CYC,
    parameter int WP_CYC = `WPULSE_CYC
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    flash_cycle_if.engine cyc, // one read or write cycle per request
    output logic flash_ce_n, // chip enable, active low
    output logic flash_oe_n, // output enable, active low
    output logic flash_we_n, // write strobe, active low
    output logic [ADDR_W-1:0] flash_addr, // word address
    output logic [DATA_W-1:0] flash_dq_out, // data driven to flash
    output logic flash_dq_oe_n, // low while we drive the data pins
    input wire logic [DATA_W-1:0] flash_dq_in // data from flash
);
    localparam logic [7:0] RD_LEN = 8'(RD_CYC);
    localparam logic [7:0] WP_LEN = 8'(WP_CYC);

    cyc_state_t st_reg;
    logic [7:0] cnt_reg;
    logic is_wr_reg;

    // output enable drops between reads so each read is a distinct cycle to the device
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= CYC_IDLE;
            cnt_reg <= 8'h00;
            is_wr_reg <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_addr <= '0;
            flash_dq_out <= '0;
            flash_dq_oe_n <= 1'b1;
            cyc.rdata <= '0;
            cyc.done <= 1'b0;
            cyc.idle <= 1'b1;
        end else begin
            cyc.done <= 1'b0;
            case (st_reg)
                CYC_IDLE: begin
                    if (cyc.req) begin
                        flash_addr <= cyc.addr;
                        flash_dq_out <= cyc.wdata;
                        is_wr_reg <= cyc.wr;
                        flash_ce_n <= 1'b0;
                        cyc.idle <= 1'b0;
                        st_reg <= CYC_STROBE;
                        if (cyc.wr) begin
                            flash_we_n <= 1'b0;
                            flash_dq_oe_n <= 1'b0;
                            cnt_reg <= WP_LEN;
                        end else begin
                            flash_oe_n <= 1'b0;
                            cnt_reg <= RD_LEN;
                        end
                    end
                end
                CYC_STROBE: begin
                    if (cnt_reg > 8'h01) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end else begin
                        if (!is_wr_reg) begin
                            cyc.rdata <= flash_dq_in;
                        end
                        flash_oe_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        st_reg <= CYC_HOLD;
                    end
                end
                CYC_HOLD: begin
                    // data held one cycle past the write strobe's rising edge
                    flash_ce_n <= 1'b1;
                    flash_dq_oe_n <= 1'b1;
                    cyc.done <= 1'b1;
                    cyc.idle <= 1'b1;
                    st_reg <= CYC_IDLE;
                end
                default: begin
                    st_reg <= CYC_IDLE;
                end
            endcase
        end
    end

    a_strobe_excl: assert property (@(posedge hclk) disable iff (!hresetn)
        !(flash_oe_n == 1'b0 && flash_we_n == 1'b0))
        else $error("read and write strobes low together");
endmodule

// ---- verification/flash_dev_model.sv ----
`timescale 1ns/1ps
module flash_dev_model (
    input wire logic hclk, // clock
    input wire logic ce_n, // enable
    input wire logic oe_n, // read strobe
    input wire logic we_n, // write strobe
    input wire logic [15:0] dq, // write data
    input wire logic load, // start algorithm
    input wire logic [1:0] mode, // 0 array 1 prog 2 fail 3 susp
    output logic [15:0] dq_in, // data out
    output logic busy_output_n // low while working
);
    logic [1:0] m_reg = 2'h0;
    logic [2:0] cnt_reg = 3'h0;
    logic tog_reg = 1'b0;
    logic oe_q = 1'b1;
    logic we_q = 1'b1;
    logic [15:0] val;
    logic [15:0] last_reg = 16'h0000;
    logic ers_reg = 1'b0;
    logic [7:0] win_cnt = 8'h00;
    // sector erase: both toggles move, window bit rises once the acceptance time-out runs out
    assign val = ers_reg ? {8'h00, 1'b0, tog_reg, 2'b00, win_cnt == 8'h00, tog_reg, 2'b00} :
        (m_reg == 2'h0) ? 16'h5A18 : {8'h00, 1'b1, (m_reg != 2'h3) & tog_reg,
        m_reg == 2'h2, 2'b00, (m_reg == 2'h3) & tog_reg, 2'b00};
    // released bus shows the inverse so a late sample cannot pass
    assign dq_in = (!oe_n && !ce_n) ? val : ~last_reg;
    assign busy_output_n = !(m_reg == 2'h1 || m_reg == 2'h2 || ers_reg);
    always @(posedge hclk) begin
        oe_q <= oe_n;
        we_q <= we_n;
        if (!oe_n) last_reg <= val;
        if (win_cnt != 8'h00) win_cnt <= win_cnt - 8'h01;
        if (load) begin
            m_reg <= mode;
            cnt_reg <= 3'h4;
            ers_reg <= 1'b0;
            win_cnt <= 8'h00;
        end else if (oe_n && !oe_q) begin
            tog_reg <= !tog_reg;
            if (m_reg == 2'h1) cnt_reg <= cnt_reg - 3'h1;
            if (m_reg == 2'h1 && cnt_reg == 3'h1) m_reg <= 2'h0;
        end else if (we_n && !we_q && dq == 16'h00F0) begin
            m_reg <= 2'h0;
        end else if (we_n && !we_q && dq == 16'h0030 && (!ers_reg || win_cnt != 8'h00)) begin
            // only the sector confirm opens a window; once it has closed, the confirm is ignored
            ers_reg <= 1'b1;
            win_cnt <= 8'h48;
        end
    end
endmodule

// ---- verification/tb_flash_poll_ctrl.sv ----
`timescale 1ns/1ps
module tb_flash_poll_ctrl;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic load = 1'b0;
    logic [1:0] mode = 2'h0;
    logic hreadyout, hresp, ce_n, oe_n, we_n, dq_oe_n, busy_n;
    logic [31:0] hrdata, r;
    logic [21:0] faddr;
    logic [15:0] dq_out, dq_in;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 hclk = ~hclk;
    flash_poll_ctrl flash_poll_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
        .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in),
        .busy_output_n(busy_n));
    flash_dev_model flash_dev_model_inst (.hclk(hclk), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .dq(dq_out), .load(load), .mode(mode), .dq_in(dq_in),
        .busy_output_n(busy_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e);
        samples_checked++;
        if (r !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, r);
        end
    endtask
    // start the device algorithm and check its busy pin
    task automatic start(input logic [1:0] m);
        load <= 1'b1;
        mode <= m;
        @(posedge hclk);
        load <= 1'b0;
        repeat (3) @(posedge hclk);
        ahb(1'b0, 8'h0C, 32'h0);
        r = {31'h0, r[8]};
        chk("busy pin", {31'h0, m[0] ^ m[1]});
    endtask
    // one control word, then the status once the op is no longer busy
    task automatic op(input logic [7:0] c, input logic [8:0] e);
        ahb(1'b1, 8'h00, {24'h0, c});
        // flags clear a cycle after the data phase, so the next read may be stale
        repeat (2) @(posedge hclk);
        do ahb(1'b0, 8'h0C, 32'h0); while (r[0] === 1'b1);
        r = r & 32'h1FF;
        chk("status", {23'h0, e});
    endtask
    task automatic run(input logic [1:0] m, input logic [2:0] o, input logic [8:0] e);
        start(m);
        op({5'h0, o}, e);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 8'h0C, 32'h0);
        chk("status reset", 32'h0);
        ahb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h0);
        ahb(1'b1, 8'h04, 32'h100);
        run(2'h0, 3'h1, 9'h006);
        ahb(1'b0, 8'h10, 32'h0);
        chk("read data", 32'h5A18);
        run(2'h1, 3'h3, 9'h006);
        ahb(1'b0, 8'h10, 32'h0);
        chk("poll data", 32'h5A18);
        run(2'h2, 3'h3, 9'h00A);
        run(2'h3, 3'h3, 9'h032);
        start(2'h2);
        ahb(1'b1, 8'h08, 32'h00F0);
        op(8'h02, 9'h006);
        // an idle bank answers the first window check with array data, whose bit 3 is set
        start(2'h0);
        op(8'h04, 9'h186);
        // the second confirm lands late in the first window; only a restart keeps it open
        op(8'h04, 9'h106);
        repeat (100) @(posedge hclk);
        op(8'h04, 9'h1C6);
        op(8'h14, 9'h106);
        // erase toggles forever with no failure, so only an abort ends this poll
        ahb(1'b1, 8'h00, 32'h3);
        repeat (30) @(posedge hclk);
        ahb(1'b1, 8'h00, 32'h80);
        repeat (2) @(posedge hclk);
        ahb(1'b0, 8'h0C, 32'h0);
        r = r & 32'h1FF;
        chk("abort status", 32'h100);
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        stop_test;
    end
endmodule
